// *** hw/option_bit_loader.sv ***
`timescale 1ns/1ps

module option_bit_loader #(
  parameter int LOAD_BYTES = option_loader_pkg::LOAD_BYTES,
  parameter int CNT_W      = option_loader_pkg::CNT_W,
  parameter int ADDR_W     = option_loader_pkg::FLASH_ADDR_W
) (
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   load_req_in,
  input  wire logic [7:0]             flash_rdata_in,
  input  wire logic                   trim_idx_wr_in,
  input  wire logic                   trim_data_wr_in,
  input  wire logic                   trim_data_rd_in,
  input  wire logic [7:0]             trim_wdata_in,
  output logic      [ADDR_W-1:0]      flash_addr_out,
  output logic                        flash_rd_out,
  output logic                        flash_info_sel_out,
  output logic                        chip_rst_b_out,
  output logic      [7:0]             trim_rdata_out,
  output logic      [8*LOAD_BYTES-1:0] option_bits_out
);

  // Local short names for the package sizes used throughout this module.
  localparam int BW = option_loader_pkg::BYTE_W;
  localparam int TB = option_loader_pkg::TRIM_BYTES;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(LOAD_BYTES - 1);
  localparam logic [CNT_W-1:0] TBASE = option_loader_pkg::TRIM_INFO_BASE;
  localparam int IW = option_loader_pkg::TRIM_IDX_W;  // Width of a trim index.
  // Working registers cover the loaded bytes and the whole trim window. The load reaches only
  // the first part of the trim window, so the trim copies above it wake at the option reset
  // value and keep what software wrote across a reload.
  localparam int REGS = (int'(TBASE) + TB > LOAD_BYTES) ? int'(TBASE) + TB : LOAD_BYTES;

  // Refuse sizes the counter or the trim window cannot serve. The check sits at elaboration,
  // so a bad parameter set never reaches a simulation or a netlist.
  if (LOAD_BYTES > (1 << CNT_W) || LOAD_BYTES <= option_loader_pkg::USER_BYTES ||
      CNT_W > ADDR_W || REGS > (1 << CNT_W) || (1 << IW) != TB) begin : g_bad_params
    $error("option_bit_loader: unsupported parameter set");
  end

  // Sequencer, capture stage and working register state.
  option_loader_pkg::load_state_type state;       // Sequencer state.
  option_loader_pkg::load_state_type next_state;  // Next sequencer state.
  logic [CNT_W-1:0]  cnt;                     // Load address counter.
  logic [CNT_W-1:0]  next_cnt;                // Next counter value.
  logic [CNT_W-1:0]  cap_sel;                 // Register select of the byte in flight.
  logic [CNT_W-1:0]  next_cap_sel;            // Next capture select.
  logic              cap_vld;                 // Flash data is valid this cycle.
  logic              next_cap_vld;            // Next capture valid.
  logic [BW-1:0]     opt [REGS];              // Option and trim working registers.
  logic [BW-1:0]     next_opt [REGS];         // Next working register values.
  logic [ADDR_W-1:0] next_addr;               // Next flash address.
  logic              next_rd;                 // Next flash read strobe.
  logic              next_info;               // Next information page select.
  logic              next_chip_rst_b;         // Next chip reset release.
  logic [BW-1:0]     next_trim_rdata;         // Next trim read data.
  logic [TB-1:0]     trim_hit;                // One-hot trim byte select.
  logic [option_loader_pkg::TRIM_IDX_W-1:0] trim_idx;  // Current trim index.

  // Maps a trim index to its load register; only 20 to 3F can result.
  // The index is only five bits wide, so no value written by software can leave the window.
  function automatic logic [CNT_W-1:0] trim_reg(input logic [IW-1:0] idx);
    trim_reg = TBASE + CNT_W'(idx);
  endfunction

  // Software trim index register. Index writes are taken at any time, even during a load;
  // only data writes are refused while the chip is held in reset.
  trim_index_reg #(
    .IDX_W (IW)
  ) i_trim_index_reg (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .wr_in      (trim_idx_wr_in),
    .wdata_in   (trim_wdata_in),
    .idx_out    (trim_idx)
  );

  // Decodes the trim index once for all trim bytes.
  // One compare per byte keeps each write enable a single gate level deep.
  generate
    for (genvar t = 0; t < TB; t++) begin : g_hit
      assign trim_hit[t] = (trim_idx == IW'(t));
    end
  endgenerate

  // Sequencer: one flash read per cycle while the load runs; the chip stays in reset.
  // Walk after reset release: the first edge leaves the wait state, the next 43 edges
  // present addresses 0 to 42 with the read strobe high, and the flash answers each
  // address one cycle later. The capture stage therefore trails the address by one
  // cycle, so the last byte lands two edges after the final address and the chip reset
  // is released on the edge after that. Holding the release until then costs a cycle
  // but guarantees that no core logic ever runs on a half-loaded option image.
  // A reload request repeats the same walk from the wait state, with the chip held
  // in reset from the edge that takes the request.
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_rd         = 1'b0;
    next_addr       = '0;
    next_info       = 1'b0;
    next_chip_rst_b = 1'b0;
    next_cap_vld    = flash_rd_out;
    next_cap_sel    = flash_addr_out[CNT_W-1:0];
    case (state)
      option_loader_pkg::LOAD_WAIT: begin
        // The counter restarts from the first program byte.
        next_state = option_loader_pkg::LOAD_RUN;
        next_cnt   = '0;
      end
      option_loader_pkg::LOAD_RUN: begin
        // Every cycle of the run issues a read; there is no idle slot between bytes.
        next_rd   = 1'b1;
        next_addr = ADDR_W'(cnt);
        // Bytes 0 and 1 come from program memory, the rest from the information page.
        next_info = (cnt >= CNT_W'(option_loader_pkg::USER_BYTES));
        // The last address ends the run; the counter then rests on it until a reload.
        if (cnt == LAST) begin
          next_state = option_loader_pkg::LOAD_DONE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      option_loader_pkg::LOAD_DONE: begin
        // Released only once the last byte has been captured. A reload request pulls the
        // chip back into reset on the very edge that takes it, so no core cycle runs on a
        // half-restored image.
        next_chip_rst_b = !flash_rd_out && !cap_vld && !load_req_in;
        // Stays here until a reload is asked for; once bytes 41 and 42 have landed, only software trim writes change the image.
        if (load_req_in) begin
          next_state = option_loader_pkg::LOAD_WAIT;
        end
      end
      default: begin
        // An unused code restarts the load, keeping the chip in reset meanwhile.
        next_state = option_loader_pkg::LOAD_WAIT;
      end
    endcase
  end

  // Working registers: filled by the load, trim copies writable by software.
  // Capture trails the address by one cycle, matching the flash read latency.
  always_comb begin
    for (int i = 0; i < REGS; i++) begin
      next_opt[i] = opt[i];
      if (cap_vld && cap_sel == CNT_W'(i)) begin
        next_opt[i] = flash_rdata_in;
      end
    end
    // Software writes are refused while the chip is held in reset, so a write can never
    // race a capture of the same byte.
    for (int t = 0; t < TB; t++) begin
      if (chip_rst_b_out && trim_data_wr_in && trim_hit[t]) begin
        next_opt[int'(TBASE) + t] = trim_wdata_in;
      end
    end
    // Reads come from the working copy, never from flash, and hold until the next read.
    next_trim_rdata = trim_rdata_out;
    if (trim_data_rd_in) begin
      next_trim_rdata = opt[trim_reg(trim_idx)];
    end
  end

  // Registers all state; flash is never written back.
  // Reset puts every working copy at the option reset value; the load then replaces the
  // flash-backed ones, while trim copies beyond the loaded window keep that value.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state              <= option_loader_pkg::LOAD_WAIT;
      cnt                <= '0;
      cap_sel            <= '0;
      cap_vld            <= 1'b0;
      flash_addr_out     <= '0;
      flash_rd_out       <= 1'b0;
      flash_info_sel_out <= 1'b0;
      chip_rst_b_out     <= 1'b0;
      trim_rdata_out     <= '0;
      for (int i = 0; i < REGS; i++) begin
        opt[i] <= option_loader_pkg::OPTION_RESET;
      end
    end else begin
      state              <= next_state;
      cnt                <= next_cnt;
      cap_sel            <= next_cap_sel;
      cap_vld            <= next_cap_vld;
      flash_addr_out     <= next_addr;
      flash_rd_out       <= next_rd;
      flash_info_sel_out <= next_info;
      chip_rst_b_out     <= next_chip_rst_b;
      trim_rdata_out     <= next_trim_rdata;
      for (int i = 0; i < REGS; i++) begin
        opt[i] <= next_opt[i];
      end
    end
  end

  // Flattened option image, byte i at bits 8*i+7:8*i.
  // It is fed from the next values so that the image never lags the working registers.
  // Trim copies above the loaded window stay internal and reach software only by reads.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      option_bits_out <= {LOAD_BYTES{option_loader_pkg::OPTION_RESET}};
    end else begin
      for (int i = 0; i < LOAD_BYTES; i++) begin
        option_bits_out[8*i +: 8] <= next_opt[i];
      end
    end
  end

endmodule

// *** hw/option_loader_pkg.sv ***
package option_loader_pkg;

  // Width of one flash byte and of one option register.
  localparam int BYTE_W = 8;
  // Number of flash reads made during the reset load.
  localparam int LOAD_BYTES = 43;
  // Width of the load counter, which supplies the low flash address bits.
  localparam int CNT_W = 6;
  // Width of the full flash address bus.
  localparam int FLASH_ADDR_W = 14;
  // Number of user option bytes taken from program memory.
  localparam int USER_BYTES = 2;
  // Number of trim bytes reachable by software.
  localparam int TRIM_BYTES = 32;
  // Width of a trim index.
  localparam int TRIM_IDX_W = 5;
  // Information page address of the first trim byte.
  localparam logic [CNT_W-1:0] TRIM_INFO_BASE = 6'h20;
  // Reset value of every option and trim working register.
  localparam logic [BYTE_W-1:0] OPTION_RESET = 8'hff;
  // Reset value of the trim index register.
  localparam logic [TRIM_IDX_W-1:0] TRIM_IDX_RESET = 5'h00;

  // Load sequencer states.
  typedef enum logic [1:0] {
    LOAD_WAIT,
    LOAD_RUN,
    LOAD_DONE
  } load_state_type;

endpackage

// *** hw/trim_index_reg.sv ***
`timescale 1ns/1ps

// Trim index register; software writes the byte index used by later data accesses.
module trim_index_reg #(
  parameter int IDX_W = option_loader_pkg::TRIM_IDX_W
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_b_in,
  input  wire logic             wr_in,
  input  wire logic [7:0]       wdata_in,
  output logic      [IDX_W-1:0] idx_out
);

  logic [IDX_W-1:0] next_idx;  // Index to be registered.

  // An index wider than the write data cannot be loaded in one write.
  if (IDX_W < 1 || IDX_W > 8) begin : g_bad_params
    $error("trim_index_reg: unsupported index width");
  end

  // Only the low bits are kept, so any written value lands inside 00H to 1FH.
  always_comb begin
    next_idx = idx_out;
    if (wr_in) begin
      next_idx = wdata_in[IDX_W-1:0];
    end
  end

  // Registers the index.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idx_out <= option_loader_pkg::TRIM_IDX_RESET;
    end else begin
      idx_out <= next_idx;
    end
  end

endmodule

// *** test/flash_model.sv ***
`timescale 1ns/1ps

// Flash array with a synchronous read of one cycle latency.
module flash_model (
  input  wire logic       clk_sys_in,
  input  wire logic [13:0] addr_in,
  input  wire logic       rd_in,
  input  wire logic       info_sel_in,
  output logic      [7:0] rdata_out
);
  initial rdata_out = 8'h00;

  // Program bytes read 40h|addr and information bytes 80h|addr, so a wrong source shows.
  // An idle bus toggles rather than holding the last byte, which would hide late captures.
  always @(posedge clk_sys_in) begin
    if (rd_in) begin
      rdata_out <= {info_sel_in, ~info_sel_in, addr_in[5:0]};
    end else begin
      rdata_out <= ~rdata_out;
    end
  end
endmodule

// *** test/option_bit_loader_asserts.sv ***
`timescale 1ns/1ps

// Watches the loader's ports; idx mirrors the trim index that software selected.
module option_bit_loader_asserts #(
  parameter int LOAD_BYTES = 43,
  parameter int CNT_W      = 6,
  parameter int ADDR_W     = 14
) (
  input wire logic                    clk_sys_in,
  input wire logic                    rst_b_in,
  input wire logic                    load_req_in,
  input wire logic [7:0]              flash_rdata_in,
  input wire logic                    trim_idx_wr_in,
  input wire logic                    trim_data_wr_in,
  input wire logic                    trim_data_rd_in,
  input wire logic [7:0]              trim_wdata_in,
  input wire logic [ADDR_W-1:0]       flash_addr_out,
  input wire logic                    flash_rd_out,
  input wire logic                    flash_info_sel_out,
  input wire logic                    chip_rst_b_out,
  input wire logic [7:0]              trim_rdata_out,
  input wire logic [8*LOAD_BYTES-1:0] option_bits_out
);
  logic [4:0] idx; // Selected trim index.
  logic       vis; // Selected trim byte also appears on the option bus.

  // Mirror of the index register; upper write bits are dropped.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idx <= 5'h00;
    end else if (trim_idx_wr_in) begin
      idx <= trim_wdata_in[4:0];
    end
  end
  assign vis = (32 + int'(idx)) < LOAD_BYTES;

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  property p_hi; flash_rd_out |-> flash_addr_out[ADDR_W-1:CNT_W] == '0; endproperty
  a_hi: assert property (p_hi) else $error("high address bits set");
  property p_first; $rose(flash_rd_out) |-> flash_addr_out == '0; endproperty
  a_first: assert property (p_first) else $error("load starts off zero");
  property p_inc; flash_rd_out && $past(flash_rd_out) |-> flash_addr_out == $past(flash_addr_out) + 1; endproperty
  a_inc: assert property (p_inc) else $error("address skipped");
  property p_len; $rose(flash_rd_out) |-> ##42 (flash_rd_out && !chip_rst_b_out && flash_addr_out == 42) ##1 !flash_rd_out; endproperty
  a_len: assert property (p_len) else $error("load length wrong");
  property p_sel; flash_rd_out |-> flash_info_sel_out == (flash_addr_out > 1); endproperty
  a_sel: assert property (p_sel) else $error("flash source wrong");
  property p_hold; $fell(flash_rd_out) |-> !chip_rst_b_out ##[1:4] chip_rst_b_out; endproperty
  a_hold: assert property (p_hold) else $error("chip reset release wrong");
  property p_stab; chip_rst_b_out && $past(chip_rst_b_out) |-> $stable(option_bits_out[255:0]); endproperty
  a_stab: assert property (p_stab) else $error("option bits changed");
  property p_wr; trim_data_wr_in && chip_rst_b_out && vis |=> option_bits_out[256+idx*8 +: 8] == $past(trim_wdata_in); endproperty
  a_wr: assert property (p_wr) else $error("trim write lost");
  property p_rd; trim_data_rd_in && chip_rst_b_out && vis |=> trim_rdata_out == $past(option_bits_out[256+idx*8 +: 8]); endproperty
  a_rd: assert property (p_rd) else $error("trim read wrong");

  c_load: cover property ($rose(chip_rst_b_out));
  c_wr: cover property (trim_data_wr_in && chip_rst_b_out && vis);
  c_rd: cover property (trim_data_rd_in && chip_rst_b_out && vis);
endmodule

bind option_bit_loader option_bit_loader_asserts #(
  .LOAD_BYTES(LOAD_BYTES), .CNT_W(CNT_W), .ADDR_W(ADDR_W)
) i_option_bit_loader_asserts (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .load_req_in(load_req_in),
  .flash_rdata_in(flash_rdata_in), .trim_idx_wr_in(trim_idx_wr_in),
  .trim_data_wr_in(trim_data_wr_in), .trim_data_rd_in(trim_data_rd_in),
  .trim_wdata_in(trim_wdata_in), .flash_addr_out(flash_addr_out), .flash_rd_out(flash_rd_out),
  .flash_info_sel_out(flash_info_sel_out), .chip_rst_b_out(chip_rst_b_out),
  .trim_rdata_out(trim_rdata_out), .option_bits_out(option_bits_out)
);

// *** test/option_bit_loader_tb.sv ***
`timescale 1ns/1ps

// Runs the reset load, trim accesses and a reload against the flash model.
module option_bit_loader_tb;
  logic         clk_sys_in, rst_b_in, load_req_in, flash_rd_out, flash_info_sel_out;
  logic         trim_idx_wr_in, trim_data_wr_in, trim_data_rd_in, chip_rst_b_out;
  logic [7:0]   trim_wdata_in, flash_rdata_in, trim_rdata_out;
  logic [13:0]  flash_addr_out;
  logic [343:0] option_bits_out;
  int           fails = 0;
  int           checks = 0;

  option_bit_loader i_option_bit_loader (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .load_req_in(load_req_in), .flash_rdata_in(flash_rdata_in),
    .trim_idx_wr_in(trim_idx_wr_in), .trim_data_wr_in(trim_data_wr_in),
    .trim_data_rd_in(trim_data_rd_in), .trim_wdata_in(trim_wdata_in),
    .flash_addr_out(flash_addr_out), .flash_rd_out(flash_rd_out),
    .flash_info_sel_out(flash_info_sel_out), .chip_rst_b_out(chip_rst_b_out),
    .trim_rdata_out(trim_rdata_out), .option_bits_out(option_bits_out));
  flash_model i_flash_model (.clk_sys_in(clk_sys_in), .addr_in(flash_addr_out),
    .rd_in(flash_rd_out), .info_sel_in(flash_info_sel_out), .rdata_out(flash_rdata_in));

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // Byte that the flash model holds at load position i.
  function automatic logic [7:0] fv(input int i);
    fv = (i < 2) ? (8'h40 | i[7:0]) : (8'h80 | i[7:0]);
  endfunction

  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // One strobe ({index, write, read}) for one cycle; ends at a falling edge to sample.
  task op(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk_sys_in);
    {trim_idx_wr_in, trim_data_wr_in, trim_data_rd_in} <= s;
    trim_wdata_in <= d;
    @(posedge clk_sys_in);
    {trim_idx_wr_in, trim_data_wr_in, trim_data_rd_in} <= 3'b000;
    @(negedge clk_sys_in);
  endtask

  task load_all;
    for (int i = 0; i < 400 && chip_rst_b_out !== 1'b1; i++) @(negedge clk_sys_in);
    chk("chip_rst", {7'h00, chip_rst_b_out}, 8'h01);
    for (int i = 0; i < 43; i++) chk("opt", option_bits_out[i*8 +: 8], fv(i));
  endtask

  task t_trim;
    for (int k = 0; k < 32; k++) begin
      op(3'b100, k[7:0]);
      op(3'b010, 8'h5a + k[7:0]);
    end
    for (int k = 0; k < 32; k++) begin
      op(3'b100, k[7:0]);
      op(3'b001, 8'h00);
      chk("rdata", trim_rdata_out, 8'h5a + k[7:0]);
      if (k < 11) chk("work", option_bits_out[256+k*8 +: 8], 8'h5a + k[7:0]);
    end
    op(3'b100, 8'he3);
    op(3'b001, 8'h00);
    chk("wrap", trim_rdata_out, 8'h5d);
    chk("info1f", option_bits_out[255:248], fv(31));
  endtask

  // A reload restores flash values; a data write during it must be ignored.
  task t_reload;
    @(posedge clk_sys_in);
    load_req_in <= 1'b1;
    @(posedge clk_sys_in);
    load_req_in <= 1'b0;
    @(negedge clk_sys_in);
    chk("hold", {7'h00, chip_rst_b_out}, 8'h00);
    op(3'b100, 8'h1f);
    op(3'b010, 8'h11);
    load_all;
    op(3'b001, 8'h00);
    chk("blocked", trim_rdata_out, 8'h79);
  endtask

  task results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    rst_b_in = 1'b0;
    load_req_in = 1'b0;
    {trim_idx_wr_in, trim_data_wr_in, trim_data_rd_in} = 3'b000;
    trim_wdata_in = 8'h00;
    repeat (6) @(posedge clk_sys_in);
    chk("rst_opt", option_bits_out[7:0], 8'hff);
    rst_b_in <= 1'b1;
    load_all;
    t_trim;
    t_reload;
    results;
  end

  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    fails++;
    results;
  end
endmodule
